/* File: src/analog_gain_offset_scaler.sv */
// Analog input scaling to a process value with gain and offset
`timescale 1ns/1ps
`default_nettype none

module analog_gain_offset_scaler #(
    parameter int MV_W = 14
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sample_valid,
    input wire logic [MV_W-1:0] analog_input_pin,
    input wire logic signed [scaler_pkg::VAL_W-1:0] cfg_low_end,
    input wire logic signed [scaler_pkg::VAL_W-1:0] cfg_high_end,
    output logic [scaler_pkg::INT_W-1:0] internal_value,
    output logic signed [scaler_pkg::VAL_W-1:0] scaled_analog_value,
    output logic result_valid
);

    logic [scaler_pkg::INT_W-1:0] internal_nxt;
    logic signed [scaler_pkg::GAIN_W-1:0] gain_nxt;
    logic signed [scaler_pkg::VAL_W-1:0] offset_nxt;
    logic signed [scaler_pkg::GAIN_W-1:0] gain_r;
    logic signed [scaler_pkg::VAL_W-1:0] offset_r;
    logic signed [scaler_pkg::VAL_W-1:0] off2_r;
    logic signed [scaler_pkg::PROD_W-1:0] prod_r;
    logic signed [scaler_pkg::VAL_W-1:0] value_nxt;
    logic v1_r;
    logic v2_r;

    // Millivolts to internal steps, clipped at full scale
    always_comb begin
        int mv;
        mv = int'(analog_input_pin);
        if (mv >= scaler_pkg::FULL_SCALE_MV) begin
            internal_nxt = scaler_pkg::INT_W'(scaler_pkg::INT_MAX);
        end else begin
            internal_nxt = scaler_pkg::INT_W'(mv / scaler_pkg::MV_PER_STEP);
        end
    end

    // Gain and offset from the two end values, clamped to legal range
    always_comb begin
        int g;
        int o;
        g = (int'(cfg_high_end) - int'(cfg_low_end))
            / scaler_pkg::GAIN_DERIVE_DIV;
        o = int'(cfg_low_end);
        if (g > scaler_pkg::GAIN_MAX) begin
            g = scaler_pkg::GAIN_MAX;
        end else if (g < -scaler_pkg::GAIN_MAX) begin
            g = -scaler_pkg::GAIN_MAX;
        end
        if (o > scaler_pkg::OFFSET_MAX) begin
            o = scaler_pkg::OFFSET_MAX;
        end else if (o < -scaler_pkg::OFFSET_MAX) begin
            o = -scaler_pkg::OFFSET_MAX;
        end
        gain_nxt = scaler_pkg::GAIN_W'(g);
        offset_nxt = scaler_pkg::VAL_W'(o);
    end

    // Stage one: capture sample and derived coefficients together
    always_ff @(posedge mclk) begin
        if (rst) begin
            internal_value <= '0;
            gain_r <= '0;
            offset_r <= '0;
            v1_r <= 1'b0;
        end else begin
            v1_r <= sample_valid;
            if (sample_valid) begin
                internal_value <= internal_nxt;
                gain_r <= gain_nxt;
                offset_r <= offset_nxt;
            end
        end
    end

    // Stage two: product kept apart from the add to ease timing
    always_ff @(posedge mclk) begin
        if (rst) begin
            prod_r <= '0;
            off2_r <= '0;
            v2_r <= 1'b0;
        end else begin
            v2_r <= v1_r;
            if (v1_r) begin
                prod_r <= $signed({1'b0, internal_value}) * gain_r;
                off2_r <= offset_r;
            end
        end
    end

    // Division truncates toward zero, so products under one give zero
    always_comb begin
        int q;
        q = int'(prod_r) / scaler_pkg::GAIN_DEN;
        value_nxt = scaler_pkg::VAL_W'(q + int'(off2_r));
    end

    // Stage three: registered result and its strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            scaled_analog_value <= '0;
            result_valid <= 1'b0;
        end else begin
            result_valid <= v2_r;
            if (v2_r) begin
                scaled_analog_value <= value_nxt;
            end
        end
    end

    a_internal_ceiling: assert property (
        @(posedge mclk) disable iff (rst)
        v1_r && $past(int'(analog_input_pin)) >= scaler_pkg::FULL_SCALE_MV
        |-> internal_value == scaler_pkg::INT_W'(scaler_pkg::INT_MAX))
        else $error("internal value not saturated at full scale");

    a_internal_linear: assert property (
        @(posedge mclk) disable iff (rst)
        sample_valid && int'(analog_input_pin) < scaler_pkg::FULL_SCALE_MV
        |=> int'(internal_value)
            == $past(int'(analog_input_pin)) / scaler_pkg::MV_PER_STEP)
        else $error("internal value not linear in input");

    a_result_latency: assert property (
        @(posedge mclk) disable iff (rst)
        sample_valid |-> ##3 result_valid)
        else $error("result strobe not three cycles after sample");

    a_gain_bounds: assert property (
        @(posedge mclk) disable iff (rst)
        v1_r |-> (int'(gain_r) <= scaler_pkg::GAIN_MAX
            && int'(gain_r) >= -scaler_pkg::GAIN_MAX
            && int'(offset_r) <= scaler_pkg::OFFSET_MAX
            && int'(offset_r) >= -scaler_pkg::OFFSET_MAX))
        else $error("gain or offset out of range");

    a_low_end_out: assert property (
        @(posedge mclk) disable iff (rst)
        v1_r && internal_value == '0
        |-> ##2 scaled_analog_value == $past(offset_r, 2))
        else $error("zero input does not give low end value");

    a_fraction_drop: assert property (
        @(posedge mclk) disable iff (rst)
        v2_r && int'(prod_r) < scaler_pkg::GAIN_DEN
            && int'(prod_r) > -scaler_pkg::GAIN_DEN
        |=> scaled_analog_value == $past(off2_r))
        else $error("fraction below one not discarded");

    // Internal value never leaves its 0..1000 span
    a_internal_range: assert property (
        @(posedge mclk) disable iff (rst)
        int'(internal_value) <= scaler_pkg::INT_MAX)
        else $error("internal value above full scale");

    // Each accepted sample moves into stage one on the next edge
    a_stage_one_strobe: assert property (
        @(posedge mclk) disable iff (rst)
        sample_valid |=> v1_r)
        else $error("stage one strobe missing");

    // Stage one always hands on to stage two
    a_stage_two_strobe: assert property (
        @(posedge mclk) disable iff (rst)
        v1_r |=> v2_r)
        else $error("stage two strobe missing");

    // Consumers may read the result at any time, so it must hold
    // between strobes rather than follow the pipe's inner state
    a_result_held: assert property (
        @(posedge mclk) disable iff (rst)
        !v2_r |=> $stable(scaled_analog_value))
        else $error("result changed without a new sample");

    // Internal value only moves on an accepted sample
    a_internal_held: assert property (
        @(posedge mclk) disable iff (rst)
        !sample_valid |=> $stable(internal_value))
        else $error("internal value changed without a sample");

    // Reset clears every output on the following edge
    a_reset_clear: assert property (
        @(posedge mclk)
        rst |=> (!result_valid && scaled_analog_value == '0
            && internal_value == '0))
        else $error("outputs not cleared by reset");

    // Every result strobe traces back to a sample three edges earlier
    a_pulse_source: assert property (
        @(posedge mclk) disable iff (rst)
        result_valid |-> $past(sample_valid, 3))
        else $error("result strobe without a sample");

    // Product checked in plain integers, independent of the widths
    a_product_form: assert property (
        @(posedge mclk) disable iff (rst)
        v1_r |=> int'(prod_r)
            == $past(int'(internal_value)) * $past(int'(gain_r)))
        else $error("product does not match gain times input");

    // Quotient truncates toward zero, then the offset is added;
    // negative products must not round down to minus one
    a_result_sum: assert property (
        @(posedge mclk) disable iff (rst)
        v2_r |=> int'(scaled_analog_value)
            == $past(int'(prod_r)) / scaler_pkg::GAIN_DEN
            + $past(int'(off2_r)))
        else $error("result is not truncated product plus offset");

endmodule

`default_nettype wire

/* File: src/scaler_pkg.sv */
// Constants shared by the analog gain and offset scaler
package scaler_pkg;
    localparam int FULL_SCALE_MV = 10000;      // 10 V full scale in millivolts
    localparam int INT_MAX = 1000;             // Internal value at full scale
    localparam int MV_PER_STEP = FULL_SCALE_MV / INT_MAX;
    localparam int GAIN_DEN = 100;             // Gain carries two decimals
    localparam int GAIN_MAX = 1000;            // +10.00 in hundredths
    localparam int OFFSET_MAX = 10000;         // Offset magnitude limit
    localparam int GAIN_DERIVE_DIV = INT_MAX / GAIN_DEN;
    localparam int INT_W = 11;                 // Holds 0..1000
    localparam int GAIN_W = 11;                // Holds -1000..+1000
    localparam int VAL_W = 16;                 // Holds -20000..+20000
    localparam int PROD_W = INT_W + 1 + GAIN_W;
    localparam int LATENCY = 3;                // Sample to result, in cycles
endpackage

/* File: tb/analog_gain_offset_scaler_test.sv */
// Self-checking bench for the analog gain and offset scaler
`timescale 1ns/1ps
`default_nettype none
module analog_gain_offset_scaler_test;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic sample_valid;
    logic [13:0] pin;
    logic signed [15:0] cfg_low_end = '0;
    logic signed [15:0] cfg_high_end = '0;
    logic [10:0] internal_value;
    logic signed [15:0] scaled_analog_value;
    logic result_valid;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    sensor_model sen (.sample_valid(sample_valid),
        .analog_input_pin(pin), .mclk(mclk));
    analog_gain_offset_scaler dut (.mclk(mclk), .rst(rst),
        .sample_valid(sample_valid), .analog_input_pin(pin),
        .cfg_low_end(cfg_low_end), .cfg_high_end(cfg_high_end),
        .internal_value(internal_value),
        .scaled_analog_value(scaled_analog_value),
        .result_valid(result_valid));
    // Clock and a hang guard sized well above the run
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // One sample through the pipe, result judged in its valid cycle
    task automatic sample(input int mv, input int lo, input int hi);
        int iv;
        int g;
        iv = (mv > 10000 ? 10000 : mv) / 10;
        g = (hi - lo) / 10;
        g = g > 1000 ? 1000 : (g < -1000 ? -1000 : g);
        @(negedge mclk);
        cfg_low_end = 16'(lo);
        cfg_high_end = 16'(hi);
        sen.convert(14'(mv));
        repeat (2) @(posedge mclk);
        #1;
        compares++;
        if (result_valid !== 1'b1 || internal_value !== 11'(iv) ||
            scaled_analog_value !== 16'(iv * g / 100 + lo)) begin
            num_errors++;
            $display("Error %0t mv %0d gave %0d", $time, mv,
                scaled_analog_value);
        end
        @(posedge mclk);
        #1;
        compares++;
        if (result_valid !== 1'b0) begin
            num_errors++;
            $display("Error %0t pulse long", $time);
        end
    endtask
    task automatic test_linear();
        sample(0, -30, 70);
        sample(3000, -30, 70);
        sample(6750, 1000, 5000);
    endtask
    task automatic test_saturate();
        sample(10000, -200, 800);
        sample(16383, -200, 800);
    endtask
    task automatic test_gain_range();
        sample(10000, -10000, 0);
        sample(5000, 0, -10000);
    endtask
    task automatic test_trunc();
        sample(20, 0, 100);
        sample(20, 0, 1000);
        sample(20, 0, 10000);
    endtask
    // Reset, check cleared outputs, then the scenarios
    initial begin
        repeat (12) @(negedge mclk);
        rst = 1'b0;
        compares++;
        if (result_valid !== 1'b0 || scaled_analog_value !== 16'h0000) begin
            num_errors++;
            $display("Error %0t reset outputs", $time);
        end
        test_linear();
        test_saturate();
        test_gain_range();
        test_trunc();
        complete_run();
    end
endmodule
`default_nettype wire

/* File: tb/sensor_model.sv */
// Converter model presenting millivolt samples to the scaler
`timescale 1ns/1ps
`default_nettype none
module sensor_model #(parameter int MV_W = 14) (
    output logic sample_valid,
    output logic [MV_W-1:0] analog_input_pin,
    input wire logic mclk
);
    // One sample per call, held a full cycle from a falling edge
    task automatic convert(input logic [MV_W-1:0] mv);
        @(negedge mclk);
        sample_valid = 1'b1;
        analog_input_pin = mv;
        @(negedge mclk);
        sample_valid = 1'b0;
        analog_input_pin = ~mv; // Stale level never looks valid
    endtask
    // Idle until the bench asks
    initial begin
        sample_valid = 1'b0;
        analog_input_pin = '0;
    end
endmodule
`default_nettype wire
